// >>> design/sisr_regs.svh
`ifndef SISR_REGS_SVH
`define SISR_REGS_SVH

// register byte offsets on the Avalon-MM slave
`define SISR_OFF_SEL1 8'h00
`define SISR_OFF_SEL2 8'h04
`define SISR_OFF_SEL3 8'h08
`define SISR_OFF_SEL4 8'h0c
`define SISR_OFF_METHOD 8'h10
`define SISR_OFF_FWD_TL 8'h14
`define SISR_OFF_REV_TL 8'h18
`define SISR_OFF_STATUS 8'h1c
`define SISR_OFF_COUNT 8'h20

// reset values
`define SISR_RST_SEL1 16'h2100
`define SISR_RST_SEL2 16'h6543
`define SISR_RST_SEL3 16'h8888
`define SISR_RST_SEL4 16'h8888
`define SISR_RST_METHOD 4'h0
`define SISR_RST_TL 10'h064
`define SISR_TL_MAX 10'h320

// control method codes that enable the inhibit function
`define SISR_METHOD_INH_GATED 4'hb
`define SISR_METHOD_INH_COUNT 4'hc

// allocation mode digit values
`define SISR_MODE_DEFAULT 4'h0
`define SISR_MODE_CUSTOM 4'h1

// selection digit codes
`define SISR_SEL_LAST_NORMAL 4'h6
`define SISR_SEL_ALWAYS_ON 4'h7
`define SISR_SEL_ALWAYS_OFF 4'h8
`define SISR_SEL_INV_BASE 4'h9

// digit positions: word 1 holds mode, run, proportional, forward prohibit
`define SISR_POS_MODE 0
`define SISR_POS_RUN 4
`define SISR_POS_PCON 8
`define SISR_POS_POT 12
// word 2 holds reverse prohibit, alarm reset, forward and reverse limit requests
`define SISR_POS_NOT 0
`define SISR_POS_ALM 4
`define SISR_POS_PCL 8
`define SISR_POS_NCL 12

// fixed default map, terminal per function
`define SISR_DEF_RUN 4'h0
`define SISR_DEF_PCON 4'h1
`define SISR_DEF_POT 4'h2
`define SISR_DEF_NOT 4'h3
`define SISR_DEF_ALM 4'h4
`define SISR_DEF_PCL 4'h5
`define SISR_DEF_NCL 4'h6

// function indices
`define SISR_FN_RUN 0
`define SISR_FN_PCON 1
`define SISR_FN_POT 2
`define SISR_FN_NOT 3
`define SISR_FN_ALM 4
`define SISR_FN_PCL 5
`define SISR_FN_NCL 6
`define SISR_FN_COUNT 7

`endif

// >>> design/sisr_pkg.sv
`default_nettype none
package sisr_pkg;
   typedef logic [3:0] sisr_digit_t;
   typedef logic [15:0] sisr_word_t;
   typedef logic [9:0] sisr_limit_t;
   typedef logic [6:0] sisr_term_t;
endpackage
`default_nettype wire

// >>> design/sisr_func_select.sv
`include "sisr_regs.svh"
`default_nettype none
module sisr_func_select
   import sisr_pkg::*;
(
   input wire sisr_digit_t sel, // source digit of one function
   input wire sisr_term_t term_level, // synchronized terminal levels, low = on
   output logic func_on // decoded function, high = active
);
   always_comb begin
      if (sel == `SISR_SEL_ALWAYS_ON) begin
         func_on = 1'b1;
      end else if (sel == `SISR_SEL_ALWAYS_OFF) begin
         func_on = 1'b0;
      end else if (sel <= `SISR_SEL_LAST_NORMAL) begin
         func_on = ~term_level[sel[2:0]];
      end else begin
         // inverted polarity loses fail-safe on a broken wire
         func_on = term_level[3'(sel - `SISR_SEL_INV_BASE)];
      end
   end
endmodule // sisr_func_select
`default_nettype wire

// >>> design/sisr_router.sv
// Summary of operation
// - control method C enables inhibit yet counts every reference pulse.
// - control method B counts pulses while inhibit off, stops and locks while on.
// - default map: terminals 0..6 feed run, proportional, prohibits, reset, limits.
// - allocation mode 0 uses fixed map, 1 uses per-function selection digits.
// - in mode 0 terminal 1 switches between proportional and inhibit by method.
// - selection words reset to 2100, 6543, 8888, 8888; word 1 digits 1-3 and all of word 2 pick a source, words 3 and 4 are unused.
// - either limit request applies both torque limits; limits 0..800, default 100.
// - digit 0-6 normal terminal, 7 always on, 8 always off, 9-F inverted.
// - several functions may share one terminal.
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`include "sisr_regs.svh"
`default_nettype none
module sisr_router
   import sisr_pkg::*;
(
   input wire logic core_clk, // system clock, 200 MHz
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic clk_en, // freezes all state while low
   input wire logic [7:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [3:0] avs_byteenable, // write byte lanes
   input wire logic [31:0] avs_writedata, // write data
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // high while the request is not yet taken
   input wire logic input_terminal_0, // terminal pin, low = on
   input wire logic input_terminal_1, // terminal pin, low = on
   input wire logic input_terminal_2, // terminal pin, low = on
   input wire logic input_terminal_3, // terminal pin, low = on
   input wire logic input_terminal_4, // terminal pin, low = on
   input wire logic input_terminal_5, // terminal pin, low = on
   input wire logic input_terminal_6, // terminal pin, low = on
   input wire logic ref_pulse_in, // position reference pulse pin
   output logic run_enable, // run enable function
   output logic proportional_control_in, // proportional control function
   output logic pulse_inhibit, // reference pulse inhibit function
   output logic forward_prohibit_in, // forward travel prohibit
   output logic reverse_prohibit_in, // reverse travel prohibit
   output logic alarm_reset_in, // alarm reset function
   output logic forward_limit_request_in, // forward torque limit request
   output logic reverse_limit_request_in, // reverse torque limit request
   output logic torque_limit_active, // external torque limits applied
   output logic [9:0] fwd_torque_limit_out, // applied forward limit, zero when inactive
   output logic [9:0] rev_torque_limit_out, // applied reverse limit, zero when inactive
   output logic position_locked, // motor held, pulses not counted
   output logic ref_pulse_counted // one-cycle strobe per counted pulse
);

   ////////////////////////////////////////////////////////////////////////////
   // synchronizers

   sisr_term_t term_pins;
   sisr_term_t term_s1_reg, term_s1_next, term_s2_reg, term_s2_next;
   logic pulse_s1_reg, pulse_s1_next, pulse_s2_reg, pulse_s2_next, pulse_s3_reg, pulse_s3_next;

   assign term_pins = {input_terminal_6, input_terminal_5, input_terminal_4, input_terminal_3,
                       input_terminal_2, input_terminal_1, input_terminal_0};

   always_comb begin
      term_s1_next = term_pins;
      term_s2_next = term_s1_reg;
      pulse_s1_next = ref_pulse_in;
      pulse_s2_next = pulse_s1_reg;
      pulse_s3_next = pulse_s2_reg;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         term_s1_reg <= 7'h7f;
         term_s2_reg <= 7'h7f;
         pulse_s1_reg <= 1'b0;
         pulse_s2_reg <= 1'b0;
         pulse_s3_reg <= 1'b0;
      end else if (clk_en) begin
         term_s1_reg <= term_s1_next;
         term_s2_reg <= term_s2_next;
         pulse_s1_reg <= pulse_s1_next;
         pulse_s2_reg <= pulse_s2_next;
         pulse_s3_reg <= pulse_s3_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register file and Avalon-MM slave, one wait cycle per access

   sisr_word_t sel1_reg, sel1_next, sel2_reg, sel2_next, sel3_reg, sel3_next, sel4_reg, sel4_next;
   sisr_digit_t method_reg, method_next;
   sisr_limit_t fwd_tl_reg, fwd_tl_next, rev_tl_reg, rev_tl_next;
   logic wait_reg, wait_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [31:0] status_word, count_reg, count_next;

   function automatic sisr_word_t merge16(input sisr_word_t old, input logic [31:0] wd, input logic [3:0] be);
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   // out-of-range limits saturate rather than wrap
   function automatic sisr_limit_t clamp_tl(input sisr_word_t v);
      clamp_tl = (v > {6'h00, `SISR_TL_MAX}) ? `SISR_TL_MAX : v[9:0];
   endfunction

   always_comb begin
      logic [31:0] rd;
      rd = 32'h0000_0000;
      sel1_next = sel1_reg;
      sel2_next = sel2_reg;
      sel3_next = sel3_reg;
      sel4_next = sel4_reg;
      method_next = method_reg;
      fwd_tl_next = fwd_tl_reg;
      rev_tl_next = rev_tl_reg;
      wait_next = wait_reg;
      rdata_next = rdata_reg;
      unique case (avs_address)
         `SISR_OFF_SEL1: rd = {16'h0000, sel1_reg};
         `SISR_OFF_SEL2: rd = {16'h0000, sel2_reg};
         `SISR_OFF_SEL3: rd = {16'h0000, sel3_reg};
         `SISR_OFF_SEL4: rd = {16'h0000, sel4_reg};
         `SISR_OFF_METHOD: rd = {28'h0000000, method_reg};
         `SISR_OFF_FWD_TL: rd = {22'h000000, fwd_tl_reg};
         `SISR_OFF_REV_TL: rd = {22'h000000, rev_tl_reg};
         `SISR_OFF_STATUS: rd = status_word;
         `SISR_OFF_COUNT: rd = count_reg;
         default: rd = 32'h0000_0000;
      endcase
      if (!wait_reg) begin
         wait_next = 1'b1;
      end else if (avs_read || avs_write) begin
         wait_next = 1'b0;
         rdata_next = avs_read ? rd : 32'h0000_0000;
      end
      // write lands at the edge where waitrequest is seen low
      if (avs_write && !wait_reg) begin
         unique case (avs_address)
            `SISR_OFF_SEL1: sel1_next = merge16(sel1_reg, avs_writedata, avs_byteenable);
            `SISR_OFF_SEL2: sel2_next = merge16(sel2_reg, avs_writedata, avs_byteenable);
            `SISR_OFF_SEL3: sel3_next = merge16(sel3_reg, avs_writedata, avs_byteenable);
            `SISR_OFF_SEL4: sel4_next = merge16(sel4_reg, avs_writedata, avs_byteenable);
            `SISR_OFF_METHOD: method_next = avs_byteenable[0] ? avs_writedata[3:0] : method_reg;
            `SISR_OFF_FWD_TL: fwd_tl_next = clamp_tl(merge16({6'h00, fwd_tl_reg}, avs_writedata, avs_byteenable));
            `SISR_OFF_REV_TL: rev_tl_next = clamp_tl(merge16({6'h00, rev_tl_reg}, avs_writedata, avs_byteenable));
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sel1_reg <= `SISR_RST_SEL1;
         sel2_reg <= `SISR_RST_SEL2;
         sel3_reg <= `SISR_RST_SEL3;
         sel4_reg <= `SISR_RST_SEL4;
         method_reg <= `SISR_RST_METHOD;
         fwd_tl_reg <= `SISR_RST_TL;
         rev_tl_reg <= `SISR_RST_TL;
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end else if (clk_en) begin
         sel1_reg <= sel1_next;
         sel2_reg <= sel2_next;
         sel3_reg <= sel3_next;
         sel4_reg <= sel4_next;
         method_reg <= method_next;
         fwd_tl_reg <= fwd_tl_next;
         rev_tl_reg <= rev_tl_next;
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
      end
   end

   assign avs_waitrequest = wait_reg;
   assign avs_readdata = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // routing

   sisr_digit_t sel_digit [`SISR_FN_COUNT];
   logic [`SISR_FN_COUNT-1:0] func_raw;
   logic mode_custom, inh_en, method_gated;

   assign mode_custom = (sel1_reg[`SISR_POS_MODE +: 4] == `SISR_MODE_CUSTOM);
   assign method_gated = (method_reg == `SISR_METHOD_INH_GATED);
   assign inh_en = method_gated || (method_reg == `SISR_METHOD_INH_COUNT);

   always_comb begin
      if (mode_custom) begin
         sel_digit[`SISR_FN_RUN] = sel1_reg[`SISR_POS_RUN +: 4];
         sel_digit[`SISR_FN_PCON] = sel1_reg[`SISR_POS_PCON +: 4];
         sel_digit[`SISR_FN_POT] = sel1_reg[`SISR_POS_POT +: 4];
         sel_digit[`SISR_FN_NOT] = sel2_reg[`SISR_POS_NOT +: 4];
         sel_digit[`SISR_FN_ALM] = sel2_reg[`SISR_POS_ALM +: 4];
         sel_digit[`SISR_FN_PCL] = sel2_reg[`SISR_POS_PCL +: 4];
         sel_digit[`SISR_FN_NCL] = sel2_reg[`SISR_POS_NCL +: 4];
      end else begin
         sel_digit[`SISR_FN_RUN] = `SISR_DEF_RUN;
         sel_digit[`SISR_FN_PCON] = `SISR_DEF_PCON;
         sel_digit[`SISR_FN_POT] = `SISR_DEF_POT;
         sel_digit[`SISR_FN_NOT] = `SISR_DEF_NOT;
         sel_digit[`SISR_FN_ALM] = `SISR_DEF_ALM;
         sel_digit[`SISR_FN_PCL] = `SISR_DEF_PCL;
         sel_digit[`SISR_FN_NCL] = `SISR_DEF_NCL;
      end
   end

   // each function decodes independently, so digits may name the same terminal
   for (genvar i = 0; i < `SISR_FN_COUNT; i++) begin : g_fn
      sisr_func_select u_sel (
         .sel(sel_digit[i]),
         .term_level(term_s2_reg),
         .func_on(func_raw[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // function outputs, pulse gating, torque limits

   logic [7:0] fn_reg, fn_next;
   logic tl_act_reg, tl_act_next, locked_reg, locked_next, counted_reg, counted_next;
   sisr_limit_t fwd_out_reg, fwd_out_next, rev_out_reg, rev_out_next;
   logic pulse_edge, count_ok;

   assign pulse_edge = pulse_s2_reg && !pulse_s3_reg;
   // only method B lets the inhibit input stop counting
   assign count_ok = !(method_gated && func_raw[`SISR_FN_PCON]);

   always_comb begin
      fn_next = {func_raw[`SISR_FN_NCL], func_raw[`SISR_FN_PCL], func_raw[`SISR_FN_ALM],
                 func_raw[`SISR_FN_NOT], func_raw[`SISR_FN_POT],
                 func_raw[`SISR_FN_PCON] && inh_en,
                 func_raw[`SISR_FN_PCON] && !inh_en,
                 func_raw[`SISR_FN_RUN]};
      locked_next = method_gated && func_raw[`SISR_FN_PCON];
      tl_act_next = func_raw[`SISR_FN_PCL] || func_raw[`SISR_FN_NCL];
      fwd_out_next = tl_act_next ? fwd_tl_reg : 10'h000;
      rev_out_next = tl_act_next ? rev_tl_reg : 10'h000;
      counted_next = pulse_edge && count_ok;
      count_next = counted_next ? count_reg + 32'h0000_0001 : count_reg;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         fn_reg <= 8'h00;
         locked_reg <= 1'b0;
         tl_act_reg <= 1'b0;
         fwd_out_reg <= 10'h000;
         rev_out_reg <= 10'h000;
         counted_reg <= 1'b0;
         count_reg <= 32'h0000_0000;
      end else if (clk_en) begin
         fn_reg <= fn_next;
         locked_reg <= locked_next;
         tl_act_reg <= tl_act_next;
         fwd_out_reg <= fwd_out_next;
         rev_out_reg <= rev_out_next;
         counted_reg <= counted_next;
         count_reg <= count_next;
      end
   end

   assign {reverse_limit_request_in, forward_limit_request_in, alarm_reset_in, reverse_prohibit_in,
           forward_prohibit_in, pulse_inhibit, proportional_control_in, run_enable} = fn_reg;
   assign torque_limit_active = tl_act_reg;
   assign fwd_torque_limit_out = fwd_out_reg;
   assign rev_torque_limit_out = rev_out_reg;
   assign position_locked = locked_reg;
   assign ref_pulse_counted = counted_reg;
   assign status_word = {14'h0000, locked_reg, tl_act_reg, fn_reg, 1'b0, term_s2_reg};

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst || !clk_en);

   sequence s_pin0_held_off;
      (!mode_custom && input_terminal_0)[*3];
   endsequence

   sequence s_gated_inhibit_edge;
      method_gated && func_raw[`SISR_FN_PCON] && pulse_edge;
   endsequence

   a_count_method_c: assert property ((method_reg == `SISR_METHOD_INH_COUNT) && pulse_edge
      |=> ref_pulse_counted && count_reg == $past(count_reg) + 32'h0000_0001)
      else $error("method C dropped a reference pulse");
   a_inhibit_hold: assert property (s_gated_inhibit_edge |=> !ref_pulse_counted && position_locked
      && $stable(count_reg))
      else $error("inhibited pulse was counted");
   a_default_map: assert property (!mode_custom |=> run_enable == !$past(term_s2_reg[0])
      && forward_prohibit_in == !$past(term_s2_reg[2]) && reverse_limit_request_in == !$past(term_s2_reg[6]))
      else $error("default map mismatch");
   a_mode_select: assert property (mode_custom && sel1_reg[`SISR_POS_RUN +: 4] == `SISR_SEL_ALWAYS_ON
      |=> run_enable)
      else $error("custom selection not applied");
   a_term1_switch: assert property (!mode_custom && inh_en
      |=> pulse_inhibit == !$past(term_s2_reg[1]) && !proportional_control_in)
      else $error("terminal 1 role not switched");
   a_reset_words: assert property ($fell(sys_rst) |-> sel1_reg == `SISR_RST_SEL1
      && sel2_reg == `SISR_RST_SEL2 && sel3_reg == `SISR_RST_SEL3 && sel4_reg == `SISR_RST_SEL4)
      else $error("selection words wrong after reset");
   a_torque_apply: assert property ((func_raw[`SISR_FN_PCL] || func_raw[`SISR_FN_NCL])
      |=> torque_limit_active && fwd_torque_limit_out == $past(fwd_tl_reg)
      && rev_torque_limit_out == $past(rev_tl_reg))
      else $error("torque limits not applied together");
   a_limit_range: assert property (fwd_tl_reg <= `SISR_TL_MAX && rev_tl_reg <= `SISR_TL_MAX)
      else $error("torque limit above range");
   a_force_off: assert property (mode_custom && sel2_reg[`SISR_POS_ALM +: 4] == `SISR_SEL_ALWAYS_OFF
      |=> !alarm_reset_in)
      else $error("forced-off function active");
   a_invert_pol: assert property (mode_custom && sel2_reg[`SISR_POS_ALM +: 4] == 4'hd
      |=> alarm_reset_in == $past(term_s2_reg[4]))
      else $error("inverted polarity wrong");
   a_shared_term: assert property (mode_custom && sel1_reg[`SISR_POS_POT +: 4] == sel2_reg[`SISR_POS_NOT +: 4]
      |=> forward_prohibit_in == reverse_prohibit_in)
      else $error("shared terminal decoded differently");
   a_sync_delay: assert property (s_pin0_held_off |=> !run_enable)
      else $error("terminal not synchronized in three cycles");

endmodule // sisr_router
`default_nettype wire

// >>> tb/sisr_host_model.sv
`default_nettype none
module sisr_host_model (
   input wire logic core_clk, // bench clock
   output logic [6:0] term_pin, // terminal pins, low = on
   output logic pulse_pin // reference pulse pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      term_pin = 7'h7f;
      pulse_pin = 1'b0;
   end
   task automatic set_terms(input logic [6:0] t);
      @(posedge core_clk);
      term_pin <= t;
   endtask
   // levels held several cycles so the two-flop sync never drops an edge
   task automatic send_pulses(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk);
         pulse_pin <= 1'b1;
         repeat (3) @(posedge core_clk);
         pulse_pin <= 1'b0;
         repeat (2) @(posedge core_clk);
      end
   endtask
endmodule // sisr_host_model
`default_nettype wire

// >>> tb/tb_servo_input_signal_router.sv
`include "sisr_regs.svh"
`default_nettype none
module tb_servo_input_signal_router;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, sys_rst, clk_en, avs_read, avs_write, avs_waitrequest;
   logic [7:0] avs_address;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata;
   logic [6:0] term;
   logic pulse, tl_act, locked, counted;
   logic [7:0] fn;
   logic [9:0] fwd_tl, rev_tl;
   logic [52:0] notes [$];
   logic [52:0] nt;
   logic [15:0] cur_w1, cur_w2;
   logic [3:0] cur_m;
   logic [6:0] cur_t;
   logic [9:0] fwd_lim, rev_lim;
   int err_count, n_tests, exp_cnt, seen_pulses;
   ////////////////////////////////////////////////////////////////////////////////
   sisr_host_model u_host (.core_clk(core_clk), .term_pin(term), .pulse_pin(pulse));
   sisr_router DUT (
      .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .input_terminal_0(term[0]), .input_terminal_1(term[1]), .input_terminal_2(term[2]),
      .input_terminal_3(term[3]), .input_terminal_4(term[4]), .input_terminal_5(term[5]),
      .input_terminal_6(term[6]), .ref_pulse_in(pulse), .run_enable(fn[0]),
      .proportional_control_in(fn[1]), .pulse_inhibit(fn[2]), .forward_prohibit_in(fn[3]),
      .reverse_prohibit_in(fn[4]), .alarm_reset_in(fn[5]), .forward_limit_request_in(fn[6]),
      .reverse_limit_request_in(fn[7]), .torque_limit_active(tl_act), .fwd_torque_limit_out(fwd_tl),
      .rev_torque_limit_out(rev_tl), .position_locked(locked), .ref_pulse_counted(counted));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // one request held until waitrequest is sampled low, released on that edge
   task automatic bus_go(input logic rd, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      int k;
      @(posedge core_clk);
      avs_read <= rd;
      avs_write <= !rd;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         err_count++;
         $display("mismatch at %0t: bus timeout", $time);
         conclude();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [52:0] exp);
      notes.push_back(exp);
      bus_go(1'b1, a, 32'h0, 4'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] be);
      bus_go(1'b0, a, {16'h0, d}, be);
   endtask
   task automatic drive_terms(input logic [6:0] t);
      u_host.set_terms(t);
      cur_t = t;
      repeat (5) @(posedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic dec(input logic [3:0] d, input logic [6:0] t);
      logic [3:0] i;
      i = d - 4'h9;
      if (d <= `SISR_SEL_LAST_NORMAL) return !t[d[2:0]];
      if (d == `SISR_SEL_ALWAYS_ON) return 1'b1;
      if (d == `SISR_SEL_ALWAYS_OFF) return 1'b0;
      return t[i[2:0]];
   endfunction
   // note: {status flag, fwd and rev limit ports, status word}
   function automatic logic [52:0] exp_stat();
      logic [3:0] s [7];
      logic [7:0] f;
      logic bc, pc, act, lk;
      if (cur_w1[3:0] == `SISR_MODE_CUSTOM) begin
         s = '{cur_w1[7:4], cur_w1[11:8], cur_w1[15:12], cur_w2[3:0], cur_w2[7:4], cur_w2[11:8], cur_w2[15:12]};
      end else begin
         s = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6};
      end
      bc = cur_m == `SISR_METHOD_INH_GATED || cur_m == `SISR_METHOD_INH_COUNT;
      pc = dec(s[1], cur_t);
      f = {dec(s[6], cur_t), dec(s[5], cur_t), dec(s[4], cur_t), dec(s[3], cur_t), dec(s[2], cur_t),
           bc & pc, !bc & pc, dec(s[0], cur_t)};
      lk = cur_m == `SISR_METHOD_INH_GATED && f[2];
      act = f[6] | f[7];
      return {1'b1, act ? {fwd_lim, rev_lim} : 20'h0, 14'h0, lk, act, f, 1'b0, cur_t};
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk) begin
      if (counted === 1'b1) seen_pulses++;
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         if (notes.size() == 0) begin
            err_count++;
            $display("mismatch at %0t: read with no expectation", $time);
         end else begin
            nt = notes.pop_front();
            check(avs_readdata, nt[31:0], "readdata");
            if (nt[52]) begin
               check({22'h0, locked, tl_act, fn}, {22'h0, nt[17:8]}, "function ports");
               check({12'h0, fwd_tl, rev_tl}, {12'h0, nt[51:32]}, "limit ports");
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [6:0] tl [3];
      logic [15:0] lv [3];
      logic [3:0] ml [3];
      logic [52:0] frz;
      sys_rst = 1'b1;
      clk_en = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      void'($urandom(35184));
      cur_w1 = `SISR_RST_SEL1;
      cur_w2 = `SISR_RST_SEL2;
      cur_m = 4'h0;
      cur_t = 7'h7f;
      fwd_lim = `SISR_RST_TL;
      rev_lim = `SISR_RST_TL;
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(`SISR_OFF_SEL1, {37'h0, 16'h2100});
      rd(`SISR_OFF_SEL2, {37'h0, 16'h6543});
      rd(`SISR_OFF_SEL3, {37'h0, 16'h8888});
      rd(`SISR_OFF_SEL4, {37'h0, 16'h8888});
      rd(`SISR_OFF_METHOD, 53'h0);
      rd(`SISR_OFF_FWD_TL, {43'h0, 10'h064});
      rd(`SISR_OFF_REV_TL, {43'h0, 10'h064});
      rd(8'h24, 53'h0);
      rd(`SISR_OFF_STATUS, exp_stat());
      $display("test reset done");
      for (int i = 0; i < 7; i++) begin
         drive_terms(~(7'h01 << i));
         rd(`SISR_OFF_STATUS, exp_stat());
      end
      $display("test default map done");
      ml = '{4'h0, `SISR_METHOD_INH_GATED, `SISR_METHOD_INH_COUNT};
      foreach (ml[j]) begin
         cur_m = ml[j];
         wr(`SISR_OFF_METHOD, {12'h0, cur_m}, 4'h1);
         for (int inh = 0; inh < 2; inh++) begin
            drive_terms(inh ? 7'h7d : 7'h7f);
            rd(`SISR_OFF_STATUS, exp_stat());
            u_host.send_pulses(3);
            if (!(cur_m == `SISR_METHOD_INH_GATED && inh == 1)) exp_cnt += 3;
            repeat (4) @(posedge core_clk);
            rd(`SISR_OFF_COUNT, {21'h0, exp_cnt[31:0]});
         end
      end
      $display("test inhibit done");
      tl = '{7'h5f, 7'h3f, 7'h7f};
      lv = '{16'h0320, 16'h0384, 16'h0000};
      foreach (tl[j]) begin
         wr(`SISR_OFF_FWD_TL, lv[j], 4'h3);
         wr(`SISR_OFF_REV_TL, 16'h0007, 4'h3);
         fwd_lim = (lv[j] > 16'h0320) ? 10'h320 : lv[j][9:0];
         rev_lim = 10'h007;
         drive_terms(tl[j]);
         rd(`SISR_OFF_FWD_TL, {43'h0, fwd_lim});
         rd(`SISR_OFF_STATUS, exp_stat());
      end
      $display("test torque limit done");
      for (int i = 0; i < 24; i++) begin
         cur_w1 = (i == 0) ? 16'h9871 : {12'($urandom_range(16'hfff, 0)), 4'h1};
         // first pass shares one terminal and forces a function off, second inverts one
         cur_w2 = (i == 0) ? 16'h8889 : (i == 1) ? 16'h88d9 : 16'($urandom);
         wr(`SISR_OFF_SEL1, cur_w1, 4'h3);
         wr(`SISR_OFF_SEL2, cur_w2, 4'h3);
         drive_terms((i == 0) ? 7'h7e : 7'($urandom));
         rd(`SISR_OFF_STATUS, exp_stat());
      end
      cur_w1 = 16'h2102;
      wr(`SISR_OFF_SEL1, cur_w1, 4'h3);
      drive_terms(7'($urandom));
      rd(`SISR_OFF_STATUS, exp_stat());
      $display("test custom map done");
      frz = exp_stat();
      clk_en <= 1'b0;
      u_host.set_terms(~cur_t);
      repeat (6) @(posedge core_clk);
      // frozen flops must still show the state from before the pin change
      check({24'h0, fn}, {24'h0, frz[15:8]}, "frozen ports");
      clk_en <= 1'b1;
      cur_t = ~cur_t;
      repeat (5) @(posedge core_clk);
      rd(`SISR_OFF_STATUS, exp_stat());
      $display("test clock enable done");
      repeat (4) @(posedge core_clk);
      check(seen_pulses, exp_cnt, "counted strobes");
      conclude();
   end
endmodule // tb_servo_input_signal_router
`default_nettype wire
